//--- fasg_pkg.sv
// Summary of operation
// - External-move writes go to flash; reads to XRAM
// - Software flash writes need write enable set
// - Page erase needs write and erase enables
// - Lock byte complement gives locked page count
// - Lock byte page locked if any bit zero
// - Unlocked pages open to every requester
// - Locked pages: debug refused, unlocked firmware resets
// - Lock page with locks: only locked firmware
// - Lock page without locks: open to all
// - Lock page erase unlocked: debug only
// - Locked lock page erased only by whole erase
// - Changing lock byte bits is forbidden
// - Reserved area refused or causes error reset
// - Error flag reads one after error reset
// - Debug violations dropped silently, no reset
// - Lock byte changes only through whole erase
// - New lock byte active after next reset
// - Scratchpad locked when all pages locked
// - Part identity register, eight bits
// - Silicon revision register, eight bits
// - Supply monitor off makes modify error reset
// - Key bytes before each modify; bad keys lock
// - Enable bits in control register, reset zero
package fasg_pkg;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0]  REV_ADDR     = 8'hE2;
   localparam logic [7:0]  PART_ADDR    = 8'hE3;
   localparam logic [7:0]  PROGRAM_STORE_CONTROL_ADDR   = 8'h8F;
   localparam logic [7:0]  KEY_ADDR     = 8'hB7;
   localparam int          WE_BIT       = 0;
   localparam int          EE_BIT       = 1;
   localparam logic [7:0]  KEY_FIRST    = 8'hA5;
   localparam logic [7:0]  KEY_SECOND   = 8'hF1;
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

   // ----------------------------------------------------------------
   // Flash geometry
   // ----------------------------------------------------------------
   localparam int          ADDR_W       = 16;
   localparam int          PAGE_SHIFT   = 9;
   localparam logic [15:0] USER_TOP     = 16'h1FFF;
   localparam logic [15:0] RSVD_BASE    = 16'h2000;
   localparam logic [15:0] SCRATCH_BASE = 16'hF000;

   typedef enum logic [1:0] {
      FASG_OP_READ,
      FASG_OP_WRITE,
      FASG_OP_ERASE
   } fasg_op_t;

   // Flash access request from either requester
   typedef struct packed {
      logic             valid;
      logic             dbg;
      logic             scratch;
      fasg_op_t         op;
      logic [15:0]      addr;
      logic [7:0]       data;
      logic [15:0]      fetch;
   } fasg_req_t;

   typedef enum logic [1:0] {
      FASG_ALLOW,
      FASG_DROP,
      FASG_FAULT
   } fasg_verdict_t;

endpackage

//--- fasg_guard.sv
`timescale 1ns/1ps
`default_nettype none
module fasg_guard #(
   parameter logic [7:0] PART_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] REV_CODE  = 8'h3C  // Arbitrary value
) (
   input  wire logic                   REF_CLK_I,
   input  wire logic                   RST_I,
   input  wire logic                   FERR_RST_I,
   input  wire logic [7:0]             SFR_ADDR_I,
   input  wire logic                   SFR_WR_I,
   input  wire logic [7:0]             SFR_WDATA_I,
   output logic      [7:0]             SFR_RDATA_O,
   input  wire fasg_pkg::fasg_req_t    REQ_I,
   input  wire logic                   EXTERNAL_MOVE_INSTRUCTION_RD_I,
   input  wire logic                   VMON_EN_I,
   input  wire logic                   VMON_RST_EN_I,
   input  wire logic                   DEV_ERASE_I,
   input  wire logic [7:0]             LOCK_BYTE_I,
   output logic                        XRAM_RD_O,
   output logic                        FL_GO_O,
   output logic                        FL_DEV_ERASE_O,
   output fasg_pkg::fasg_verdict_t     VERDICT_O,
   output logic                        FERR_RESET_O,
   output logic                        FERR_FLAG_O,
   output logic [7:0]                  LOCK_ACTIVE_O
);
   import fasg_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]  lock_ff;
   logic        samp_ff;
   logic        we_ff, ee_ff;
   // Key sequencer states; a dead key stays dead until device reset
   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_HALF,
      KEY_ARMED,
      KEY_DEAD
   } fasg_key_t;
   fasg_key_t   key_ff;
   logic        ferr_ff;
   logic        fault_ff;
   logic        go_ff;
   logic        derase_ff;
   fasg_verdict_t verdict_ff;
   fasg_verdict_t nxt_verdict;

   function automatic logic [6:0] page_of(input logic [15:0] a);
      page_of = a[15:PAGE_SHIFT];
   endfunction

   // Lock byte sampled on first clock after reset release
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         lock_ff <= ERASED_BYTE;
         samp_ff <= 1'b0;
      end else if (!samp_ff) begin
         lock_ff <= LOCK_BYTE_I;
         samp_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Access classification
   // ----------------------------------------------------------------
   logic [7:0] n_locked;
   logic       any_locked;
   logic [6:0] lock_pg;
   logic       is_rsvd, is_lockpg, is_lockbyte, pg_locked, fetch_locked;
   logic       modify;
   assign n_locked     = ~lock_ff;
   assign any_locked   = (lock_ff != ERASED_BYTE);
   assign lock_pg      = page_of(USER_TOP);
   assign is_rsvd      = !REQ_I.scratch && REQ_I.addr >= RSVD_BASE;
   assign is_lockpg    = !REQ_I.scratch && page_of(REQ_I.addr) == lock_pg;
   assign is_lockbyte  = REQ_I.addr == USER_TOP && !REQ_I.scratch;
   assign modify       = REQ_I.op != FASG_OP_READ;
   // Page index compare; scratchpad locked only when all pages are
   assign pg_locked    = REQ_I.scratch
                       ? ({1'b0, n_locked} >= {2'b00, lock_pg})
                       : ({2'b00, page_of(REQ_I.addr)} < {1'b0, n_locked});
   // Firmware origin from fetch address page
   assign fetch_locked = any_locked &&
      ((page_of(REQ_I.fetch) < n_locked[6:0] && n_locked[7] == 1'b0)
       || n_locked[7] || page_of(REQ_I.fetch) == lock_pg);

   // Verdict per access; debug never faults, only drops
   always_comb begin
      logic deny;
      deny = 1'b0;
      nxt_verdict = FASG_ALLOW;
      if (is_rsvd)
         deny = 1'b1;
      else if (is_lockbyte && modify)
         deny = !(REQ_I.dbg && REQ_I.op == FASG_OP_ERASE && !any_locked)
                || REQ_I.op == FASG_OP_WRITE;
      else if (is_lockpg && REQ_I.op == FASG_OP_ERASE)
         deny = !(REQ_I.dbg && !any_locked);
      else if (is_lockpg)
         deny = any_locked && !(!REQ_I.dbg && fetch_locked);
      else if (pg_locked)
         deny = REQ_I.dbg || !fetch_locked;
      if (!deny && !REQ_I.dbg && modify) begin
         if (!VMON_EN_I || !VMON_RST_EN_I)
            deny = 1'b1;
      end
      if (deny)
         nxt_verdict = REQ_I.dbg ? FASG_DROP : FASG_FAULT;
      else if (!REQ_I.dbg && modify) begin
         // Enables and key gate firmware modify; silently no effect
         if (!we_ff || key_ff != KEY_ARMED)
            nxt_verdict = FASG_DROP;
         else if (REQ_I.op == FASG_OP_ERASE && !ee_ff)
            nxt_verdict = FASG_DROP;
      end
   end

   // ----------------------------------------------------------------
   // Control register and key sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         we_ff <= 1'b0;
         ee_ff <= 1'b0;
      end else if (SFR_WR_I && SFR_ADDR_I == PROGRAM_STORE_CONTROL_ADDR) begin
         we_ff <= SFR_WDATA_I[WE_BIT];
         ee_ff <= SFR_WDATA_I[EE_BIT];
      end
   end

   // Key lock re-arms after each firmware modify outside the reserved area; bad order kills until reset
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I)
         key_ff <= KEY_IDLE;
      else if (key_ff == KEY_DEAD)
         key_ff <= KEY_DEAD;
      else if (REQ_I.valid && !REQ_I.dbg && modify && !is_rsvd)
         key_ff <= (key_ff == KEY_ARMED) ? KEY_IDLE : KEY_DEAD;
      else if (SFR_WR_I && SFR_ADDR_I == KEY_ADDR) begin
         if (key_ff == KEY_IDLE && SFR_WDATA_I == KEY_FIRST)
            key_ff <= KEY_HALF;
         else if (key_ff == KEY_HALF && SFR_WDATA_I == KEY_SECOND)
            key_ff <= KEY_ARMED;
         else
            key_ff <= KEY_DEAD;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         go_ff      <= 1'b0;
         fault_ff   <= 1'b0;
         derase_ff  <= 1'b0;
         verdict_ff <= FASG_ALLOW;
      end else begin
         go_ff      <= REQ_I.valid && nxt_verdict == FASG_ALLOW;
         fault_ff   <= REQ_I.valid && nxt_verdict == FASG_FAULT;
         derase_ff  <= DEV_ERASE_I;
         verdict_ff <= REQ_I.valid ? nxt_verdict : verdict_ff;
      end
   end

   // Error flag survives the error reset it causes
   always_ff @(posedge REF_CLK_I) begin
      if (FERR_RST_I)
         ferr_ff <= 1'b0;
      else if (fault_ff)
         ferr_ff <= 1'b1;
   end

   assign XRAM_RD_O      = EXTERNAL_MOVE_INSTRUCTION_RD_I;
   assign FL_GO_O        = go_ff;
   assign FL_DEV_ERASE_O = derase_ff;
   assign VERDICT_O      = verdict_ff;
   assign FERR_RESET_O   = fault_ff;
   assign FERR_FLAG_O    = ferr_ff;
   assign LOCK_ACTIVE_O  = lock_ff;

   // Identity and control register readback
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I)
         SFR_RDATA_O <= 8'h00;
      else case (SFR_ADDR_I)
         PART_ADDR:  SFR_RDATA_O <= PART_CODE;
         REV_ADDR:   SFR_RDATA_O <= REV_CODE;
         PROGRAM_STORE_CONTROL_ADDR: SFR_RDATA_O <= {6'h00, ee_ff, we_ff};
         default:    SFR_RDATA_O <= 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // All checks share the one clock; reset silences them
   default clocking chk_cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RST_I);

   // Debug port: violations are dropped, never reset the device
   a_dbg_no_fault: assert property (
      REQ_I.valid && REQ_I.dbg |=> !FERR_RESET_O)
      else $error("debug access raised error reset");
   a_dbg_verdict: assert property (
      REQ_I.valid && REQ_I.dbg |=> VERDICT_O != FASG_FAULT)
      else $error("debug access got fault verdict");
   a_rsvd_dbg_drop: assert property (
      REQ_I.valid && REQ_I.dbg && is_rsvd |=> VERDICT_O == FASG_DROP)
      else $error("reserved debug access not dropped");
   a_locked_dbg: assert property (
      REQ_I.valid && REQ_I.dbg && pg_locked && !is_lockpg && !is_rsvd
      |=> VERDICT_O == FASG_DROP)
      else $error("locked page open to debug");
   a_lockpg_dbg: assert property (
      REQ_I.valid && REQ_I.dbg && is_lockpg && any_locked |=> !FL_GO_O)
      else $error("lock page open to debug while locked");

   // Firmware: locked pages open only to code that runs from them
   a_rsvd_fw_fault: assert property (
      REQ_I.valid && !REQ_I.dbg && is_rsvd |=> FERR_RESET_O)
      else $error("reserved access missed error reset");
   a_locked_fw_unl: assert property (
      REQ_I.valid && !REQ_I.dbg && pg_locked && !is_lockpg && !is_rsvd
      && !fetch_locked |=> FERR_RESET_O)
      else $error("unlocked code reached a locked page");
   a_locked_fw_ok: assert property (
      REQ_I.valid && !REQ_I.dbg && pg_locked && !is_lockpg && !is_rsvd
      && fetch_locked && REQ_I.op == FASG_OP_READ |=> FL_GO_O)
      else $error("locked code refused its own page");
   a_unlocked_open: assert property (
      REQ_I.valid && !pg_locked && !is_lockpg && !is_rsvd
      && REQ_I.op == FASG_OP_READ |=> FL_GO_O)
      else $error("unlocked page read refused");
   a_lockpg_fw_unl: assert property (
      REQ_I.valid && !REQ_I.dbg && is_lockpg && any_locked
      && !fetch_locked && REQ_I.op == FASG_OP_READ |=> FERR_RESET_O)
      else $error("lock page read by unlocked code");
   a_lockpg_fw_ok: assert property (
      REQ_I.valid && !REQ_I.dbg && is_lockpg && any_locked
      && fetch_locked && REQ_I.op == FASG_OP_READ |=> FL_GO_O)
      else $error("lock page refused to locked code");
   a_lockpg_free: assert property (
      REQ_I.valid && is_lockpg && !any_locked
      && REQ_I.op == FASG_OP_READ |=> FL_GO_O)
      else $error("lock page read refused while unlocked");
   a_lockpg_erase_fw: assert property (
      REQ_I.valid && !REQ_I.dbg && is_lockpg && REQ_I.op == FASG_OP_ERASE
      |=> FERR_RESET_O)
      else $error("firmware erased the lock page");
   a_lockpg_erase_dbg: assert property (
      REQ_I.valid && REQ_I.dbg && is_lockpg && !is_lockbyte && !any_locked
      && REQ_I.op == FASG_OP_ERASE |=> FL_GO_O)
      else $error("debug erase of free lock page refused");
   a_lockbyte_write: assert property (
      REQ_I.valid && is_lockbyte && REQ_I.op == FASG_OP_WRITE |=> !FL_GO_O)
      else $error("lock byte rewritten");
   a_lockbyte_fw_wr: assert property (
      REQ_I.valid && !REQ_I.dbg && is_lockbyte && REQ_I.op == FASG_OP_WRITE
      |=> FERR_RESET_O)
      else $error("firmware lock byte write missed error reset");

   // Modify gates; a cheap software slip must never reach the cells
   a_we_gate: assert property (
      REQ_I.valid && !REQ_I.dbg && modify && !we_ff |=> !FL_GO_O)
      else $error("write went through without enable");
   a_erase_ee: assert property (
      REQ_I.valid && !REQ_I.dbg && REQ_I.op == FASG_OP_ERASE && !ee_ff
      |=> !FL_GO_O)
      else $error("erase without erase enable");
   a_key_gate: assert property (
      REQ_I.valid && !REQ_I.dbg && modify && key_ff != KEY_ARMED
      |=> !FL_GO_O)
      else $error("modify passed without key");
   a_key_dead: assert property (
      key_ff == KEY_DEAD |=> key_ff == KEY_DEAD)
      else $error("dead key revived before reset");
   a_vmon_fault: assert property (
      REQ_I.valid && !REQ_I.dbg && modify
      && (!VMON_EN_I || !VMON_RST_EN_I) |=> FERR_RESET_O)
      else $error("modify with monitor off missed error reset");

   // Flag, lock sampling, identity and pass-through paths
   a_ferr_sticky: assert property (
      FERR_RESET_O && !FERR_RST_I |=> FERR_FLAG_O)
      else $error("error flag not set");
   a_ferr_hold: assert property (
      FERR_FLAG_O && !FERR_RST_I |=> FERR_FLAG_O)
      else $error("error flag lost without clear");
   a_lock_stable: assert property (
      samp_ff |=> $stable(LOCK_ACTIVE_O))
      else $error("lock region changed before reset");
   a_xram_read: assert property (
      EXTERNAL_MOVE_INSTRUCTION_RD_I |-> XRAM_RD_O)
      else $error("external-move read missed data memory");
   a_dev_erase: assert property (
      DEV_ERASE_I |=> FL_DEV_ERASE_O)
      else $error("whole erase not passed on");
   a_part_read: assert property (
      SFR_ADDR_I == PART_ADDR |=> SFR_RDATA_O == PART_CODE)
      else $error("part identity read wrong");
   a_rev_read: assert property (
      SFR_ADDR_I == REV_ADDR |=> SFR_RDATA_O == REV_CODE)
      else $error("revision read wrong");

   c_fw_write: cover property (FL_GO_O && we_ff);
   c_fault: cover property (FERR_RESET_O);
   c_dbg_drop: cover property (VERDICT_O == FASG_DROP);
   c_erase_go: cover property (FL_GO_O && ee_ff);
   c_lock_free: cover property (samp_ff && LOCK_ACTIVE_O == ERASED_BYTE);
endmodule
`default_nettype wire

//--- fasg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// CPU core and debug host model
// ------------------------------
module fasg_host_model
   import fasg_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic [7:0] sfr_rdata_i,
   output var  fasg_req_t req_o,
   output var  logic [7:0] sfr_addr_o,
   output var  logic      sfr_wr_o,
   output var  logic [7:0] sfr_wdata_o
);
   initial begin
      req_o = '0;
      sfr_addr_o = '0;
      sfr_wr_o = 1'b0;
      sfr_wdata_o = '0;
   end
   // One register write; data inverted once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i); #1;
      sfr_addr_o = a;
      sfr_wdata_o = d;
      sfr_wr_o = 1'b1;
      @(posedge clk_i); #1;
      sfr_wr_o = 1'b0;
      sfr_wdata_o = ~d;
   endtask
   // Register read, data one cycle after address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i); #1;
      sfr_addr_o = a;
      @(posedge clk_i); #1;
      d = sfr_rdata_i;
   endtask
   // Enables then keys; keys needed before each modify
   task automatic arm(input logic ee);
      wr(PROGRAM_STORE_CONTROL_ADDR, {6'h00, ee, 1'b1});
      wr(KEY_ADDR, KEY_FIRST);
      wr(KEY_ADDR, KEY_SECOND);
   endtask
   // One request; address scrambled once released
   task automatic go(input logic dbg, input fasg_op_t op,
                     input logic [15:0] a, input logic [15:0] f);
      @(posedge clk_i); #1;
      req_o = '{1'b1, dbg, 1'b0, op, a, 8'h3C, f};
      @(posedge clk_i); #1;
      req_o.valid = 1'b0;
      req_o.addr = ~a;
      req_o.fetch = ~f;
   endtask
endmodule
`default_nettype wire

//--- flash_access_security_guard_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin \
   error_cnt++; $display("mismatch %s exp %h got %h", n, e, a); end end
module flash_access_security_guard_tb;
   import fasg_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ferr_rst = 1'b1, external_move_instruction = 1'b0;
   logic vmon = 1'b1, vmon_rst = 1'b1, dev_er = 1'b0, go_o, fr_o, fl_o;
   logic xram_o, der_o, sfr_wr;
   logic [7:0] lock = 8'hFB, rdat, sfr_a, sfr_d, lock_o, v8;
   fasg_req_t req;
   fasg_verdict_t verd;
   int error_cnt = 0, checks = 0;
   // ------------------------------
   // Clock, model and design
   // ------------------------------
   initial forever #5 clk = ~clk;
   fasg_host_model HOST (.clk_i(clk), .sfr_rdata_i(rdat), .req_o(req),
      .sfr_addr_o(sfr_a), .sfr_wr_o(sfr_wr), .sfr_wdata_o(sfr_d));
   fasg_guard DUT (.REF_CLK_I(clk), .RST_I(rst), .FERR_RST_I(ferr_rst),
      .SFR_ADDR_I(sfr_a), .SFR_WR_I(sfr_wr), .SFR_WDATA_I(sfr_d),
      .SFR_RDATA_O(rdat), .REQ_I(req), .EXTERNAL_MOVE_INSTRUCTION_RD_I(external_move_instruction),
      .VMON_EN_I(vmon), .VMON_RST_EN_I(vmon_rst), .DEV_ERASE_I(dev_er),
      .LOCK_BYTE_I(lock), .XRAM_RD_O(xram_o), .FL_GO_O(go_o),
      .FL_DEV_ERASE_O(der_o), .VERDICT_O(verd), .FERR_RESET_O(fr_o),
      .FERR_FLAG_O(fl_o), .LOCK_ACTIVE_O(lock_o));
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic do_reset(input int n);
      rst = 1'b1;
      repeat (n) @(posedge clk);
      #1 rst = 1'b0;
      @(posedge clk); #1;
   endtask
   // Verdict with its grant and reset pulses, sampled after the answer
   task automatic req_chk(input logic d, input fasg_op_t op,
      input logic [15:0] a, input logic [15:0] f, input fasg_verdict_t v);
      HOST.go(d, op, a, f);
      `CHK("verdict", v, verd)
      `CHK("grant", v == FASG_ALLOW, go_o)
      `CHK("err_reset", v == FASG_FAULT, fr_o)
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs;
      `CHK("lock", 8'hFB, lock_o)
      `CHK("flag_init", 1'b0, fl_o)
      HOST.rd(PART_ADDR, v8);
      `CHK("part", 8'h5A, v8)
      HOST.rd(REV_ADDR, v8);
      `CHK("rev", 8'h3C, v8)
      external_move_instruction = 1'b1;
      #1;
      `CHK("xram", 1'b1, xram_o)
      external_move_instruction = 1'b0;
      dev_er = 1'b1;
      @(posedge clk); #1;
      `CHK("dev_erase", 1'b1, der_o)
      dev_er = 1'b0;
      $display("test regs done");
   endtask
   // Four locked pages plus lock page; fetch 0x0100 is locked code
   task automatic t_allow;
      HOST.arm(1'b0);
      req_chk(0, FASG_OP_WRITE, 16'h1000, 16'h1000, FASG_ALLOW);
      req_chk(1, FASG_OP_READ, 16'h0800, 16'h0000, FASG_ALLOW);
      req_chk(0, FASG_OP_READ, 16'h01FF, 16'h0100, FASG_ALLOW);
      req_chk(0, FASG_OP_READ, 16'h1FFF, 16'h0100, FASG_ALLOW);
      HOST.arm(1'b1);
      HOST.rd(PROGRAM_STORE_CONTROL_ADDR, v8);
      `CHK("ctl", 8'h03, v8)
      req_chk(0, FASG_OP_ERASE, 16'h0800, 16'h0100, FASG_ALLOW);
      $display("test allow done");
   endtask
   // Debug violations dropped; same places fault from unlocked code
   task automatic t_deny;
      logic [15:0] tab [4] = '{16'h0000, 16'h07FF, 16'h1FFF, 16'h2000};
      foreach (tab[i]) begin
         req_chk(1, FASG_OP_READ, tab[i], 0, FASG_DROP);
         req_chk(0, FASG_OP_READ, tab[i], 16'h1000, FASG_FAULT);
      end
      req_chk(1, FASG_OP_WRITE, 16'h1FFF, 0, FASG_DROP);
      `CHK("flag", 1'b1, fl_o)
      $display("test deny done");
   endtask
   // New lock byte counts only after reset; flag survives the reset
   task automatic t_unlocked;
      lock = 8'hFF;
      `CHK("lock_held", 8'hFB, lock_o)
      do_reset(2);
      `CHK("flag_kept", 1'b1, fl_o)
      `CHK("lock_new", 8'hFF, lock_o)
      req_chk(1, FASG_OP_READ, 16'h1FFF, 0, FASG_ALLOW);
      req_chk(1, FASG_OP_ERASE, 16'h1E00, 0, FASG_ALLOW);
      HOST.arm(1'b1);
      req_chk(0, FASG_OP_ERASE, 16'h1E00, 16'h0100, FASG_FAULT);
      ferr_rst = 1'b1;
      @(posedge clk); #1 ferr_rst = 1'b0;
      `CHK("flag_clr", 1'b0, fl_o)
      $display("test unlocked done");
   endtask
   // Supply monitor off faults; erase without erase enable is dropped
   task automatic t_guard;
      vmon_rst = 1'b0;
      HOST.arm(1'b0);
      req_chk(0, FASG_OP_WRITE, 16'h1000, 16'h1000, FASG_FAULT);
      vmon_rst = 1'b1;
      vmon = 1'b0;
      HOST.arm(1'b0);
      req_chk(0, FASG_OP_WRITE, 16'h1000, 16'h1000, FASG_FAULT);
      vmon = 1'b1;
      do_reset(2);
      HOST.arm(1'b0);
      req_chk(0, FASG_OP_ERASE, 16'h1000, 16'h1000, FASG_DROP);
      HOST.wr(PROGRAM_STORE_CONTROL_ADDR, 8'h00);
      HOST.wr(KEY_ADDR, KEY_FIRST);
      HOST.wr(KEY_ADDR, KEY_SECOND);
      req_chk(0, FASG_OP_WRITE, 16'h1000, 16'h1000, FASG_DROP);
      $display("test guard done");
   endtask
   // ------------------------------
   // Main sequence and watchdog
   // ------------------------------
   initial begin
      do_reset(20);
      ferr_rst = 1'b0;
      t_regs();
      t_allow();
      t_deny();
      t_unlocked();
      t_guard();
      close_out();
   end
   initial begin
      #100us;
      error_cnt++;
      close_out();
   end
endmodule
`default_nettype wire
